// [rtl/soc_defs.vh]
/*
 * soc_defs.vh: shared constants of the safety output channel block
 * (hold time, test pulse width, state codes).
 * Assumes a 100 MHz system clock; included by bare name.
 */
`ifndef SOC_DEFS_VH
`define SOC_DEFS_VH

// =====================================================================
// timing
// =====================================================================
`define SOC_CLK_MHZ          100
`define SOC_HOLD_MS          1000
`define SOC_HOLD_CYC         (`SOC_HOLD_MS * 1000 * `SOC_CLK_MHZ)
`define SOC_PULSE_US         640
`define SOC_PULSE_CYC        (`SOC_PULSE_US * `SOC_CLK_MHZ)
`define SOC_PERIOD_MS        10
`define SOC_PERIOD_CYC       (`SOC_PERIOD_MS * 1000 * `SOC_CLK_MHZ)
`define SOC_CUT_US           100
`define SOC_CUT_CYC          (`SOC_CUT_US * `SOC_CLK_MHZ)

// =====================================================================
// self-test states
// =====================================================================
`define SOC_ST_IDLE          2'b00
`define SOC_ST_CUT           2'b01
`define SOC_ST_DONE          2'b10
`define SOC_ST_FAIL          2'b11

`endif

// [rtl/soc_output_stage.v]
/*
 * soc_output_stage.v: safety output stage with single/dual evaluation,
 * wiring fault diagnosis, error hold, overcurrent, supply monitoring
 * and supply cutoff self-test.
 * Assumes pin readbacks, overcurrent and supply flags are asynchronous;
 * safety data and configuration come from logic on clk_sys.
 */
// What this block does
// - dual mode drives two terminals from one safety output bit
// - dual mode: error on either terminal turns both pair terminals off
// - single mode: each terminal follows its own bit, 0 off, 1 on
// - dual mode pair follows shared bit, on only while both fault-free
// - test-pulse error status held at least one second
// - without pulses detect supply contact off, ground fault on, on/off short
// - with pulses also detect supply contact on and both-on shorts
// - overcurrent turns that terminal off
// - overcurrent raises a short-circuit event
// - supply out of range turns all terminals off
// - supply monitoring disabled when all terminals unused
// - failed cutoff self-test turns all terminals off
// - cutoff self-test runs once per power-on only
// - supply present before refreshing: test on entering refreshing
// - supply rising after refreshing: test when supply turns on
// - with pulses insert 640 us off pulses while commanded on
`timescale 1ns/10ps
`default_nettype none
`include "soc_defs.vh"

module soc_output_stage #(
   parameter N         = 4,
   parameter HOLD_CYC  = `SOC_HOLD_CYC,
   parameter PULSE_CYC = `SOC_PULSE_CYC,
   parameter PERIOD_CYC = `SOC_PERIOD_CYC,
   parameter CUT_CYC   = `SOC_CUT_CYC
) (
   input  wire         clk_sys,
   input  wire         reset_n,
   input  wire [N-1:0] safeData,
   input  wire [N-1:0] dualMode,
   input  wire [N-1:0] termUsed,
   input  wire         pulseEnable,
   input  wire         refreshing,
   input  wire [N-1:0] pinReadback,
   input  wire [N-1:0] overCurrent,
   input  wire         supplyOk,
   input  wire         supplyPresent,
   input  wire         cutoffSense,
   output reg  [N-1:0] termOut,
   output reg  [N-1:0] termError,
   output reg  [N-1:0] shortEvent,
   output reg          supplyErrEvent,
   output reg          shortFlag,
   output reg          supplyFlag,
   output reg          selfTestFlag,
   output reg          supplyCutoff,
   output reg          selfTestDone
);

   // =====================================================================
   // input synchronisers
   // =====================================================================
   reg [N-1:0] rbMeta, rbSync, ocMeta, ocSync;
   reg [2:0]   miscMeta, miscSync;
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rbMeta   <= {N{1'b0}};
         rbSync   <= {N{1'b0}};
         ocMeta   <= {N{1'b0}};
         ocSync   <= {N{1'b0}};
         // supply-ok bit resets to its healthy level so release raises no false event
         miscMeta <= 3'h1;
         miscSync <= 3'h1;
      end else begin
         rbMeta   <= pinReadback;
         rbSync   <= rbMeta;
         ocMeta   <= overCurrent;
         ocSync   <= ocMeta;
         miscMeta <= {cutoffSense, supplyPresent, supplyOk};
         miscSync <= miscMeta;
      end
   end
   wire supOkS   = miscSync[0];
   wire supPresS = miscSync[1];
   wire cutS     = miscSync[2];

   // =====================================================================
   // test pulse timing
   // =====================================================================
   reg [31:0] pulseCnt;
   reg        pulseLow;
   // off window sits at the start of each period; readback settles by its end
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pulseCnt <= 32'h0000_0000;
         pulseLow <= 1'b0;
      end else begin
         if (pulseCnt >= PERIOD_CYC - 1)
            pulseCnt <= 32'h0000_0000;
         else
            pulseCnt <= pulseCnt + 32'h0000_0001;
         pulseLow <= pulseEnable && (pulseCnt < PULSE_CYC);
      end
   end
   // sample readback at the last cycle of the off window
   wire pulseCheck = pulseEnable && (pulseCnt == PULSE_CYC);

   // =====================================================================
   // command mapping
   // =====================================================================
   // dual pairs use the even bit of the pair as the shared command
   reg [N-1:0] cmd;
   integer i, j, k, m, p;
   always @* begin
      cmd = safeData;
      for (i = 0; i < N; i = i + 1)
         if (dualMode[i & ~1])
            cmd[i] = safeData[i & ~1];
   end

   // =====================================================================
   // wiring diagnosis
   // =====================================================================
   // off with readback high covers supply contact and on/off shorts;
   // on with readback low covers ground fault; pulse window readback high
   // covers supply contact while on and shorts between two on outputs;
   // readback lags the drive by the two sync stages, so it is held
   // against the drive delayed by two cycles, not the live one
   reg [N-1:0] wireFault;
   reg [N-1:0] onD1, onD2;
   always @* begin
      wireFault = {N{1'b0}};
      for (j = 0; j < N; j = j + 1) begin
         if (termUsed[j]) begin
            if (!onD2[j] && rbSync[j] && !cmd[j])
               wireFault[j] = 1'b1;
            if (onD2[j] && !rbSync[j])
               wireFault[j] = 1'b1;
            if (pulseCheck && cmd[j] && rbSync[j])
               wireFault[j] = 1'b1;
         end
      end
   end

   // =====================================================================
   // error latch with hold time, per terminal
   // =====================================================================
   reg [31:0] holdCnt [0:N-1];
   reg [N-1:0] rawErr;
   always @* begin
      rawErr = wireFault | (ocSync & termUsed);
      for (k = 0; k < N; k = k + 1)
         if (dualMode[k & ~1] && (k | 1) < N)
            rawErr[k] = wireFault[k & ~1] | wireFault[k | 1]
                      | ((ocSync[k & ~1] | ocSync[k | 1]) & termUsed[k]);
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         termError  <= {N{1'b0}};
         shortEvent <= {N{1'b0}};
         for (m = 0; m < N; m = m + 1)
            holdCnt[m] <= 32'h0000_0000;
      end else begin
         shortEvent <= ocSync & termUsed & ~termError;
         for (m = 0; m < N; m = m + 1) begin
            if (rawErr[m]) begin
               termError[m] <= 1'b1;
               holdCnt[m]   <= HOLD_CYC;
            end else if (holdCnt[m] != 32'h0000_0000) begin
               holdCnt[m] <= holdCnt[m] - 32'h0000_0001;
            end else if (!cmd[m]) begin
               termError[m] <= 1'b0;
            end
         end
      end
   end

   // =====================================================================
   // supply monitoring
   // =====================================================================
   wire monActive = |termUsed;
   wire supBad    = monActive && !supOkS;
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         supplyFlag     <= 1'b0;
         supplyErrEvent <= 1'b0;
      end else begin
         supplyFlag     <= supBad;
         supplyErrEvent <= supBad && !supplyFlag;
      end
   end

   // =====================================================================
   // supply cutoff self-test, once per power-on
   // =====================================================================
   reg [1:0]  testState, next_testState;
   reg [31:0] cutCnt;
   always @* begin
      next_testState = testState;
      case (testState)
         `SOC_ST_IDLE:
            // covers both supply-first and refreshing-first orders
            if (refreshing && supPresS)
               next_testState = `SOC_ST_CUT;
         `SOC_ST_CUT:
            if (cutCnt == 32'h0000_0000)
               next_testState = cutS ? `SOC_ST_FAIL : `SOC_ST_DONE;
         `SOC_ST_DONE: next_testState = `SOC_ST_DONE;
         `SOC_ST_FAIL: next_testState = `SOC_ST_FAIL;
         default:      next_testState = `SOC_ST_IDLE;
      endcase
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         testState    <= `SOC_ST_IDLE;
         cutCnt       <= 32'h0000_0000;
         supplyCutoff <= 1'b0;
         selfTestFlag <= 1'b0;
         selfTestDone <= 1'b0;
      end else begin
         testState <= next_testState;
         if (testState == `SOC_ST_IDLE)
            cutCnt <= CUT_CYC;
         else if (cutCnt != 32'h0000_0000)
            cutCnt <= cutCnt - 32'h0000_0001;
         supplyCutoff <= (next_testState == `SOC_ST_CUT);
         selfTestFlag <= (next_testState == `SOC_ST_FAIL);
         selfTestDone <= next_testState[1];
      end
   end

   // =====================================================================
   // output drive and status
   // =====================================================================
   wire allOff = supBad || selfTestFlag || supplyCutoff;
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         termOut   <= {N{1'b0}};
         shortFlag <= 1'b0;
         onD1      <= {N{1'b0}};
         onD2      <= {N{1'b0}};
      end else begin
         shortFlag <= |(ocSync & termUsed);
         onD1      <= termOut;
         onD2      <= onD1;
         for (p = 0; p < N; p = p + 1)
            termOut[p] <= termUsed[p] && cmd[p] && !termError[p] && !rawErr[p]
                          && !ocSync[p] && !allOff && !pulseLow;
      end
   end

endmodule
`default_nettype wire

// [sim/soc_output_props.sv]
/* assertions on the ports of soc_output_stage, bound below.
   assumes one clock domain and an async active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module soc_output_props #(
   parameter N = 4
) (
   input wire logic         clk_sys,
   input wire logic         reset_n,
   input wire logic [N-1:0] safeData,
   input wire logic [N-1:0] dualMode,
   input wire logic         pulseEnable,
   input wire logic         refreshing,
   input wire logic [N-1:0] overCurrent,
   input wire logic         supplyOk,
   input wire logic         supplyPresent,
   input wire logic [N-1:0] termOut,
   input wire logic [N-1:0] termError,
   input wire logic         supplyErrEvent,
   input wire logic         shortFlag,
   input wire logic         supplyFlag,
   input wire logic         selfTestFlag,
   input wire logic         supplyCutoff,
   input wire logic         selfTestDone
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // ======================
   // steps and properties
   // inputs pass a 2-ff sync, so three samples before the answer
   sequence s_ready;
      (refreshing && supplyPresent && !selfTestDone) [*3];
   endsequence
   sequence s_ocOn;
      overCurrent[1] [*3];
   endsequence
   property p_supplyOff;
      (!supplyOk) [*3] |=> termOut == '0;
   endproperty
   property p_supplyEvt;
      supplyErrEvent |-> supplyFlag ##1 !supplyErrEvent;
   endproperty
   property p_overCur;
      s_ocOn |=> !termOut[1];
   endproperty
   property p_shortFlag;
      $rose(overCurrent[1]) |-> ##[1:4] shortFlag;
   endproperty
   property p_single;
      (!dualMode[0] && !pulseEnable && supplyOk && selfTestDone && !selfTestFlag && !supplyFlag
         && !termError[0] && !supplyCutoff) |=> termError[0] || termOut[0] == $past(safeData[0]);
   endproperty
   property p_dualPair;
      (dualMode[0] && !pulseEnable) [*2] |-> termOut[1] == termOut[0];
   endproperty
   property p_testFail;
      selfTestFlag |-> termOut == '0;
   endproperty
   property p_once;
      selfTestDone |=> selfTestDone && !supplyCutoff;
   endproperty
   property p_start;
      s_ready |-> ##[0:1] supplyCutoff;
   endproperty
   a_supplyOff: assert property (p_supplyOff) else $error("drive with bad supply");
   a_supplyEvt: assert property (p_supplyEvt) else $error("supply event shape");
   a_overCur: assert property (p_overCur) else $error("drive kept on overcurrent");
   a_shortFlag: assert property (p_shortFlag) else $error("no short flag");
   a_single: assert property (p_single) else $error("single drive wrong");
   a_dualPair: assert property (p_dualPair) else $error("pair split");
   a_testFail: assert property (p_testFail) else $error("drive after failed test");
   a_once: assert property (p_once) else $error("cutoff repeated");
   a_start: assert property (p_start) else $error("cutoff not started");
endmodule
bind soc_output_stage soc_output_props #(.N(N)) soc_output_props_inst (.clk_sys(clk_sys),
   .reset_n(reset_n), .safeData(safeData), .dualMode(dualMode), .pulseEnable(pulseEnable),
   .refreshing(refreshing), .overCurrent(overCurrent), .supplyOk(supplyOk),
   .supplyPresent(supplyPresent), .termOut(termOut), .termError(termError),
   .supplyErrEvent(supplyErrEvent), .shortFlag(shortFlag), .supplyFlag(supplyFlag),
   .selfTestFlag(selfTestFlag), .supplyCutoff(supplyCutoff), .selfTestDone(selfTestDone));
`default_nettype wire

// [sim/soc_load_model.sv]
/* load on the output terminals: relays and drive inputs.
   assumes the bench picks which wires touch the supply. */
`timescale 1ns/10ps
`default_nettype none
module soc_load_model #(
   parameter N = 4
) (
   input  wire logic [N-1:0] termOut,
   input  wire logic [N-1:0] stuckHigh,
   input  wire logic         supplyCutoff,
   input  wire logic         cutFails,
   output logic      [N-1:0] pinReadback,
   output logic              cutoffSense
);
   // ======================
   // wiring
   // a wire shorted to the supply reads high whatever the drive
   assign pinReadback = termOut | stuckHigh;
   // a healthy cutoff removes supply, so sense stays low
   assign cutoffSense = supplyCutoff & cutFails;
endmodule
`default_nettype wire

// [sim/tb_soc_output_stage.sv]
/* bench for soc_output_stage with the load model.
   assumes shortened counts so the hold fits a short run. */
`timescale 1ns/10ps
`default_nettype none
module tb_soc_output_stage;
   localparam HOLD = 50;
   logic       clk_sys = 1'b0;
   logic       reset_n = 1'b0;
   logic [3:0] safeData = 4'h0;
   logic [3:0] dualMode = 4'h0;
   logic [3:0] termUsed = 4'hf;
   logic [3:0] overCurrent = 4'h0;
   logic [3:0] stuckHigh = 4'h0;
   logic       pulseEnable = 1'b0;
   logic       refreshing = 1'b0;
   logic       supplyOk = 1'b1;
   logic       supplyPresent = 1'b0;
   logic       cutFails = 1'b0;
   wire  [3:0] pinReadback, termOut, termError, shortEvent;
   wire        cutoffSense, shortFlag, supplyFlag, selfTestFlag, supplyCutoff, selfTestDone;
   wire        supplyErrEvent;
   wire  [2:0] flags = {selfTestDone, ~termOut[0], termError[0]};
   int         n_fail = 0;
   int         comparisons = 0;
   int         n;
   soc_output_stage #(.N(4), .HOLD_CYC(HOLD), .PULSE_CYC(4), .PERIOD_CYC(40), .CUT_CYC(5))
      soc_output_stage_inst (.clk_sys(clk_sys), .reset_n(reset_n), .safeData(safeData),
      .dualMode(dualMode), .termUsed(termUsed), .pulseEnable(pulseEnable),
      .refreshing(refreshing), .pinReadback(pinReadback), .overCurrent(overCurrent),
      .supplyOk(supplyOk), .supplyPresent(supplyPresent), .cutoffSense(cutoffSense),
      .termOut(termOut), .termError(termError), .shortEvent(shortEvent),
      .supplyErrEvent(supplyErrEvent),
      .shortFlag(shortFlag), .supplyFlag(supplyFlag), .selfTestFlag(selfTestFlag),
      .supplyCutoff(supplyCutoff), .selfTestDone(selfTestDone));
   soc_load_model soc_load_model_inst (.termOut(termOut), .stuckHigh(stuckHigh),
      .supplyCutoff(supplyCutoff), .cutFails(cutFails), .pinReadback(pinReadback),
      .cutoffSense(cutoffSense));
   // ======================
   // tasks
   initial forever #5 clk_sys = ~clk_sys;
   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // inputs change only at falling edges, away from sampling
   task automatic cyc(input int k);
      repeat (k) @(negedge clk_sys);
   endtask
   task automatic print_verdict;
      $display("%0d comparisons, %0d mismatches", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // bounded wait; a hang ends the run as a failure
   task automatic waitFor(input int b);
      for (int i = 0; i < 200 && !flags[b]; i++) cyc(1);
      if (!flags[b]) begin
         n_fail++;
         print_verdict();
      end
   endtask
   // ======================
   // sequence of tests
   initial begin
      cyc(8);
      reset_n = 1'b1;
      refreshing = 1'b1;
      cyc(6);
      chk(supplyCutoff, 1'b0);
      supplyPresent = 1'b1;
      cyc(5);
      chk(supplyCutoff, 1'b1);
      waitFor(2);
      chk(selfTestFlag, 1'b0);
      supplyPresent = 1'b0;
      cyc(4);
      supplyPresent = 1'b1;
      cyc(8);
      chk(supplyCutoff, 1'b0);
      $display("self-test done");
      safeData = 4'h5;
      cyc(2);
      chk(termOut, 4'h5);
      safeData = 4'ha;
      cyc(2);
      chk(termOut, 4'ha);
      dualMode = 4'h5;
      safeData = 4'h1;
      cyc(2);
      chk(termOut, 4'h3);
      safeData = 4'h0;
      stuckHigh = 4'h8;
      cyc(5);
      chk(termError & 4'h8, 4'h8);
      safeData = 4'h4;
      cyc(2);
      chk(termOut, 4'h0);
      stuckHigh = 4'h0;
      cyc(HOLD - 8);
      chk(termError & 4'h8, 4'h8);
      cyc(20);
      chk(termOut, 4'h0);
      safeData = 4'h0;
      cyc(3);
      safeData = 4'h4;
      cyc(3);
      chk(termOut, 4'hc);
      $display("dual done");
      dualMode = 4'h0;
      safeData = 4'h1;
      pulseEnable = 1'b1;
      for (n = 0; n < 50 && !termOut[0]; n++) cyc(1);
      waitFor(1);
      for (n = 0; n < 20 && !termOut[0]; n++) cyc(1);
      chk(4'(n), 4'h4);
      stuckHigh = 4'h1;
      waitFor(0);
      chk(termOut & 4'h1, 4'h0);
      stuckHigh = 4'h0;
      pulseEnable = 1'b0;
      safeData = 4'h2;
      overCurrent = 4'h2;
      cyc(3);
      chk(shortEvent & 4'h2, 4'h2);
      cyc(2);
      chk(termOut & 4'h2, 4'h0);
      chk(shortFlag, 1'b1);
      overCurrent = 4'h0;
      safeData = 4'h4;
      supplyOk = 1'b0;
      cyc(3);
      chk(supplyErrEvent, 1'b1);
      cyc(1);
      chk(termOut, 4'h0);
      chk(supplyFlag, 1'b1);
      $display("faults done");
      reset_n = 1'b0;
      refreshing = 1'b0;
      termUsed = 4'h0;
      cutFails = 1'b1;
      cyc(2);
      reset_n = 1'b1;
      cyc(4);
      refreshing = 1'b1;
      cyc(3);
      chk(supplyCutoff, 1'b1);
      waitFor(2);
      chk(selfTestFlag, 1'b1);
      chk(supplyFlag, 1'b0);
      supplyOk = 1'b1;
      termUsed = 4'hf;
      safeData = 4'h1;
      cyc(3);
      chk(termOut, 4'h0);
      $display("failed self-test done");
      print_verdict();
   end
endmodule
`default_nettype wire
